/* pcp_pkg.sv */
// Package for the processor control and interrupt pin unit.
// Assumes one bus clock at 20 MHz; all pin inputs are asynchronous to it.
package pcp_pkg;
	localparam int          CLK_MHZ        = 20;
	// Length of the reset-out pulse for the reset instruction, in ns.
	localparam int          RESET_OUT_N_NS        = 25600;
	localparam int          RESET_OUT_N_CYCLES    = (RESET_OUT_N_NS * CLK_MHZ) / 1000;
	localparam int          LEVEL_W        = 3;
	localparam logic [2:0]  LEVEL_NONE     = 3'h0;
	localparam logic [2:0]  MASK_RESET     = 3'h7;
	// Autovector numbers start at this base plus the level.
	localparam logic [7:0]  AUTOVEC_BASE   = 8'h18;
	localparam logic        DRIVE_SMALL    = 1'h0;

	typedef enum logic [1:0] {
		PCP_RUN,
		PCP_RESET_EXC,
		PCP_RESET_OUT_N
	} pcp_state_e;
endpackage : pcp_pkg

/* pcp_sync_if.sv */
// Interface carrying the synchronised pin levels inside the top, from the synchroniser output bus to the logic.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
`default_nettype none
interface pcp_sync_if;
	logic       reset_in_n;
	logic       cache_off_n;
	logic       autovector_req_n;
	logic       xfer_ack_n;
	logic [2:0] irq_level_n;
	modport src (output reset_in_n, cache_off_n, autovector_req_n, xfer_ack_n, irq_level_n);
	modport dst (input  reset_in_n, cache_off_n, autovector_req_n, xfer_ack_n, irq_level_n);
endinterface : pcp_sync_if
`default_nettype wire

/* pcp_sync.sv */
// Two-flop synchroniser for a group of asynchronous input pins.
// Assumes the pins are asynchronous to clk; the flops themselves carry no reset.
`timescale 1ns/1ps
`default_nettype none
module pcp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Pins and synchronised result
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] sync
);
	logic [W-1:0] meta;

	// Reset-in itself passes here, so these flops are left out of reset on purpose.
	// A reset pin held low then reaches the logic the moment the core reset lifts.
	always_ff @(posedge clk) begin
		meta <= pin;
		sync <= meta;
	end
endmodule : pcp_sync
`default_nettype wire

/* pcp_top.sv */
// Processor control and interrupt pin unit: cache-off, reset in/out, interrupt
// level decode, pending flag and autovector request.
// Assumes core signals on clk; all pins but the static scan pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module pcp_top (
	// Clock and pin reset
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       reset_in_n,
	// Cache control pin and core side
	input  wire logic       cache_off_n,
	input  wire logic       cache_boundary,
	output logic            cache_use_en,
	output logic            snoop_en,
	// Reset status and reset instruction
	output logic            reset_exc,
	input  wire logic       reset_instr,
	output logic            reset_out_n,
	output logic            reset_instr_done,
	output logic            bus_oe,
	output logic            drive_strength,
	// Interrupt pins and core side
	input  wire logic [2:0] irq_level_n,
	input  wire logic [2:0] status_reg_mask,
	output logic            irq_pending_n,
	output logic [2:0]      irq_level,
	// Interrupt acknowledge
	input  wire logic       iack_cycle,
	input  wire logic       xfer_ack_n,
	input  wire logic       autovector_req_n,
	input  wire logic [7:0] bus_vector,
	output logic            vector_valid,
	output logic            vector_auto,
	output logic [7:0]      vector_num,
	// Scan-compatibility pins, held static by the board
	input  wire logic [1:0] scan_compat_pins
);
	// Seven pin bits: reset, cache-off, autovector, acknowledge and three level bits.
	localparam int         PIN_W     = 7;
	localparam logic [9:0] RESET_OUT_N_LAST = 10'(pcp_pkg::RESET_OUT_N_CYCLES - 1);

	pcp_sync_if s ();
	pcp_pkg::pcp_state_e state;
	pcp_pkg::pcp_state_e next_state;
	logic [9:0]          reset_out_n_cnt;
	logic [2:0]          pend_level;
	logic [PIN_W-1:0]    pin_bus;
	logic [PIN_W-1:0]    sync_bus;

	assign pin_bus = {reset_in_n, cache_off_n, autovector_req_n, xfer_ack_n, irq_level_n};

	pcp_sync #(
		.W (PIN_W)
	) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.pin  (pin_bus),
		.sync (sync_bus)
	);

	// Only the synchronised copies reach the logic below.
	assign s.reset_in_n       = sync_bus[6];
	assign s.cache_off_n      = sync_bus[5];
	assign s.autovector_req_n = sync_bus[4];
	assign s.xfer_ack_n       = sync_bus[3];
	assign s.irq_level_n      = sync_bus[2:0];

	// A reset pin pulse shorter than one clock can be missed; hold it low longer.
	wire reset_seen = !nrst || !s.reset_in_n;
	wire in_reset   = reset_seen || (state == pcp_pkg::PCP_RESET_EXC);

	wire [2:0] level_dec = ~s.irq_level_n;
	// Level 7 cannot be masked, so it counts as above every mask.
	// level above mask
	wire level_above = (level_dec > status_reg_mask) || (level_dec == 3'h7);
	wire level_req   = (level_dec != pcp_pkg::LEVEL_NONE) && level_above;

	wire reset_out_n_done = (reset_out_n_cnt == RESET_OUT_N_LAST);

	always_comb begin
		next_state = state;
		unique case (state)
			pcp_pkg::PCP_RUN:       if (reset_instr) next_state = pcp_pkg::PCP_RESET_OUT_N;
			pcp_pkg::PCP_RESET_EXC: next_state = pcp_pkg::PCP_RUN;
			pcp_pkg::PCP_RESET_OUT_N:      if (reset_out_n_done) next_state = pcp_pkg::PCP_RUN;
			default:                next_state = pcp_pkg::PCP_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset_seen) begin
			state <= pcp_pkg::PCP_RESET_EXC;
		end else begin
			state <= next_state;
		end
	end

	// The count only runs while the pulse stands, so it starts from zero each time.
	wire [9:0] next_reset_out_n_cnt = (state == pcp_pkg::PCP_RESET_OUT_N) ? reset_out_n_cnt + 10'h001 : 10'h000;

	always_ff @(posedge clk) begin
		if (reset_seen) begin
			reset_out_n_cnt <= 10'h000;
		end else begin
			reset_out_n_cnt <= next_reset_out_n_cnt;
		end
	end

	wire next_reset_out_n      = !(next_state == pcp_pkg::PCP_RESET_OUT_N);
	wire next_reset_instr_done = (state == pcp_pkg::PCP_RESET_OUT_N) && reset_out_n_done;

	always_ff @(posedge clk) begin
		if (reset_seen) begin
			reset_out_n <= 1'h1;
		end else begin
			reset_out_n <= next_reset_out_n;
		end
	end

	always_ff @(posedge clk) begin
		if (reset_seen) begin
			reset_instr_done <= 1'h0;
		end else begin
			reset_instr_done <= next_reset_instr_done;
		end
	end

	// Caches fall back to usable in reset, since the pin level is ignored there.
	// caches off at boundary
	always_ff @(posedge clk) begin
		if (in_reset) begin
			cache_use_en <= 1'h1;
		end else if (cache_boundary) begin
			cache_use_en <= s.cache_off_n;
		end
	end

	assign snoop_en = 1'h1;

	assign bus_oe    = !in_reset;
	assign reset_exc = in_reset;
	assign drive_strength = pcp_pkg::DRIVE_SMALL;

	wire       next_irq_pending_n = !level_req;
	wire [2:0] next_irq_level     = level_req ? level_dec : pcp_pkg::LEVEL_NONE;
	// The autovector uses the last level seen pending, not the live pins.
	wire [2:0] next_pend_level    = level_req ? level_dec : pend_level;

	always_ff @(posedge clk) begin
		if (in_reset) begin
			irq_pending_n <= 1'h1;
		end else begin
			irq_pending_n <= next_irq_pending_n;
		end
	end

	always_ff @(posedge clk) begin
		if (in_reset) begin
			irq_level <= pcp_pkg::LEVEL_NONE;
		end else begin
			irq_level <= next_irq_level;
		end
	end

	always_ff @(posedge clk) begin
		if (in_reset) begin
			pend_level <= pcp_pkg::LEVEL_NONE;
		end else begin
			pend_level <= next_pend_level;
		end
	end

	wire ack_taken = iack_cycle && !s.xfer_ack_n;
	wire use_auto  = ack_taken && !s.autovector_req_n;

	wire [7:0] auto_vector     = pcp_pkg::AUTOVEC_BASE + {5'h00, pend_level};
	wire [7:0] vector_pick     = use_auto ? auto_vector : bus_vector;
	wire [7:0] next_vector_num = ack_taken ? vector_pick : vector_num;

	always_ff @(posedge clk) begin
		if (in_reset) begin
			vector_valid <= 1'h0;
			vector_auto  <= 1'h0;
		end else begin
			vector_valid <= ack_taken;
			vector_auto  <= use_auto;
		end
	end

	always_ff @(posedge clk) begin
		if (in_reset) begin
			vector_num <= 8'h00;
		end else begin
			vector_num <= next_vector_num;
		end
	end

	// no test logic here; scan pins unused by design.
	wire unused_scan = ^scan_compat_pins;
endmodule : pcp_top
`default_nettype wire

/* pcp_far.sv */
// Far-side model: interrupt prioritiser, reset logic and acknowledging slave.
// Assumes the bench steps its requests by non-blocking assignment at a rising edge.
`timescale 1ns/1ps
`default_nettype none
module pcp_far (
	// Requests from the bench
	input  wire logic [2:0] level,
	input  wire logic       ack, autov, rst_req,
	// Pins toward the unit
	output logic      [2:0] irq_level_n,
	output logic            xfer_ack_n, autovector_req_n, reset_in_n
);
	assign irq_level_n      = ~level;
	assign xfer_ack_n       = ~ack;
	assign autovector_req_n = ~(ack & autov);
	assign reset_in_n       = ~rst_req;
endmodule : pcp_far
`default_nettype wire

/* pcp_asserts.sv */
// Checker on the ports of the control and interrupt pin unit.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pcp_asserts (
	// Watched ports
	input wire logic       clk, nrst, cache_off_n, cache_boundary, cache_use_en, snoop_en,
	input wire logic       reset_exc, reset_instr, reset_out_n, reset_instr_done, bus_oe,
	input wire logic       drive_strength, irq_pending_n, vector_valid, vector_auto,
	input wire logic [2:0] irq_level_n, status_reg_mask, irq_level,
	input wire logic [7:0] vector_num
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Three edges cover the pin synchroniser and the output register.
	sequence s_lvl(p, m);
		(irq_level_n == p && status_reg_mask == m && !reset_exc)[*3];
	endsequence
	sequence s_pulse;
		##[512:512] (reset_out_n && reset_instr_done);
	endsequence
	a_snoop_on: assert property (snoop_en) else $error("snoop off");
	a_drive_small: assert property (drive_strength == 1'h0) else $error("drive");
	a_reset_float: assert property (reset_exc |-> !bus_oe) else $error("bus_oe");
	a_reset_out_n_start: assert property (reset_instr && reset_out_n && !reset_exc
		|=> !reset_out_n) else $error("reset_out_n start");
	a_reset_out_n_len: assert property ($fell(reset_out_n) |-> s_pulse) else $error("reset_out_n len");
	a_lvl_none: assert property (s_lvl(3'h7, 3'h0) |=> irq_pending_n) else $error("none");
	a_lvl_above: assert property (s_lvl(3'h2, 3'h3)
		|=> !irq_pending_n && irq_level == 3'h5) else $error("above");
	a_lvl_equal: assert property (s_lvl(3'h4, 3'h3) |=> irq_pending_n) else $error("eq");
	a_cache_off: assert property ((!cache_off_n)[*2] ##1 (!cache_off_n && cache_boundary)
		|=> !cache_use_en) else $error("cache off");
	a_cache_hold: assert property (!cache_boundary && !reset_exc
		|=> $stable(cache_use_en)) else $error("cache hold");
	a_auto_vec: assert property (vector_valid && vector_auto
		|-> vector_num[7:3] == 5'h03) else $error("autovec");
endmodule : pcp_asserts
bind pcp_top pcp_asserts u_pcp_asserts (.*);
`default_nettype wire

/* processor_control_interrupt_pins_tb.sv */
// Self-checking bench for the control and interrupt pin unit.
// Assumes the far-side model and the checker bound to the top.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) checks_done++; if ((a) !== (e)) begin errors++; \
	$display("Error %s exp %h got %h", n, e, a); end
module processor_control_interrupt_pins_tb;
	typedef struct packed {logic [2:0] lv, mk; logic pn; logic [2:0] el;} pcp_row_s;
	pcp_row_s   rows [6] = '{'{3'h0, 3'h0, 1'h1, 3'h0}, '{3'h2, 3'h1, 1'h0, 3'h2},
		'{3'h3, 3'h3, 1'h1, 3'h0}, '{3'h7, 3'h7, 1'h0, 3'h7}, '{3'h5, 3'h4, 1'h0, 3'h5},
		'{3'h5, 3'h3, 1'h0, 3'h5}};
	logic       clk, nrst, reset_in_n, cache_off_n, cache_boundary, cache_use_en, snoop_en;
	logic       reset_exc, reset_instr, reset_out_n, reset_instr_done, bus_oe, drive_strength;
	logic       irq_pending_n, iack_cycle, xfer_ack_n, autovector_req_n, vector_valid;
	logic       vector_auto, ack, autov, rst_req;
	logic [2:0] irq_level_n, status_reg_mask, irq_level, level;
	logic [7:0] bus_vector, vector_num;
	logic [1:0] scan_compat_pins = 2'h3;
	int         errors, checks_done, cnt;
	pcp_top u_pcp_top (.*);
	pcp_far u_pcp_far (.*);
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic cache_step(logic v);
		@(posedge clk);
		cache_off_n <= v;
		tick(4);
		`CHK("cache_hold", 1'h1 ^ v, cache_use_en)
		@(posedge clk);
		cache_boundary <= 1'h1;
		@(posedge clk);
		cache_boundary <= 1'h0;
		tick(1);
		`CHK("cache_use_en", v, cache_use_en)
	endtask : cache_step
	// Acknowledge is held until the unit reports the vector.
	task automatic iack_run(logic av, logic [7:0] exp);
		@(posedge clk);
		iack_cycle <= 1'h1;
		ack <= 1'h1;
		autov <= av;
		for (cnt = 0; cnt < 10 && vector_valid !== 1'h1; cnt++) tick(1);
		`CHK("vector_num", exp, vector_num)
		`CHK("vector_auto", av, vector_auto)
		@(posedge clk);
		ack <= 1'h0;
		iack_cycle <= 1'h0;
		tick(3);
	endtask : iack_run
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		#(2000 * 50);
		errors++;
		conclude();
	end
	initial begin
		{nrst, level, ack, autov, rst_req, cache_boundary, reset_instr, iack_cycle} = '0;
		cache_off_n = 1'h1;
		status_reg_mask = 3'h7;
		bus_vector = 8'h40;
		tick(5);
		`CHK("bus_oe", 1'h0, bus_oe)
		`CHK("reset_out_n", 1'h1, reset_out_n)
		@(posedge clk);
		nrst <= 1'h1;
		foreach (rows[i]) begin
			@(posedge clk);
			level <= rows[i].lv;
			status_reg_mask <= rows[i].mk;
			tick(5);
			`CHK("irq_pending_n", rows[i].pn, irq_pending_n)
			`CHK("irq_level", rows[i].el, irq_level)
		end
		iack_run(1'h1, pcp_pkg::AUTOVEC_BASE + 8'h05);
		iack_run(1'h0, 8'h40);
		cache_step(1'h0);
		cache_step(1'h1);
		@(posedge clk);
		reset_instr <= 1'h1;
		@(posedge clk);
		reset_instr <= 1'h0;
		tick(1);
		`CHK("reset_out_n", 1'h0, reset_out_n)
		// A second request during the pulse must not restart it.
		@(posedge clk);
		reset_instr <= 1'h1;
		@(posedge clk);
		reset_instr <= 1'h0;
		for (cnt = 0; cnt < 600 && reset_instr_done !== 1'h1; cnt++) tick(1);
		// The pulse fell three edges before this count began.
		`CHK("reset_out_n_cycles", pcp_pkg::RESET_OUT_N_CYCLES - 3, cnt)
		`CHK("reset_out_n", 1'h1, reset_out_n)
		@(posedge clk);
		rst_req <= 1'h1;
		tick(4);
		`CHK("reset_exc", 1'h1, reset_exc)
		`CHK("bus_oe", 1'h0, bus_oe)
		`CHK("irq_pending_n", 1'h1, irq_pending_n)
		@(posedge clk);
		rst_req <= 1'h0;
		tick(5);
		`CHK("bus_oe", 1'h1, bus_oe)
		`CHK("irq_pending_n", 1'h0, irq_pending_n)
		conclude();
	end
endmodule : processor_control_interrupt_pins_tb
`default_nettype wire
